// *** src/intc_map.svh ***
`ifndef INTC_MAP_SVH
`define INTC_MAP_SVH
// register word indices (byte address = 4 * index)
`define IDX_REQ_FLAGS   8'hFA
`define IDX_TMR_MODE    8'hF0
`define IDX_TMR0_RELOAD   8'hF1
`define IDX_TMR0_PRESCALE 8'hF2
`define IDX_TMR1_RELOAD   8'hF3
`define IDX_TMR1_PRESCALE 8'hF4
`define IDX_PRIORITY    8'hF5
`define IDX_MASK        8'hF6
`define IDX_SP_CONTROL  8'hF7
`define IDX_ANALOG_CTRL 8'hF8
// field positions
`define MASK_GLOBAL     7
`define MASK_PROTECT    6
`define SP_CLEAR_BIT    0
`define ANALOG_BIT      0
`define PRE_CONT_BIT    0
`define TMR0_LOAD       0
`define TMR0_RUN        1
`define TMR1_LOAD       2
`define TMR1_RUN        3
`define TMR_EXT_MODE_LO 4
`define TMR1_INT_SRC    6
`define TMR_CASCADE     7
// external input roles
`define EXT_CLOCK       2'h0
`define EXT_GATE        2'h1
`define EXT_TRIG_ONCE   2'h2
`define EXT_TRIG_RETRIG 2'h3
// reset values and timing
`define RST_BYTE        8'h00
`define RST_PRIORITY    3'h0
`define DIV4_LAST       2'h3
`define NUM_REQ         6
`endif

// *** src/intc_pkg.sv ***
package intc_pkg;
    typedef enum logic {ST_IDLE, ST_WAIT} grant_state_type;
endpackage

// *** src/irq_timer.sv ***
`timescale 1ns/100ps
`include "intc_map.svh"
module irq_timer (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic       load,
    input  wire logic       continuous,
    input  wire logic [7:0] reload_val,
    input  wire logic [5:0] divisor,
    output logic      [7:0] count,
    output logic            done,
    output logic            eoc
);
    logic [5:0] pre_cnt;
    logic [5:0] pre_last;
    logic       step;

    // a divisor of zero wraps to 63, giving the divide-by-64 setting
    assign pre_last = divisor - 6'h01;
    assign step     = tick & run & ~done & (pre_cnt == pre_last);

    // prescaler, cleared on restart so the first period is whole
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= 6'h00;
        end else if (load) begin
            pre_cnt <= 6'h00;
        end else if (tick & run & ~done) begin
            pre_cnt <= (pre_cnt == pre_last) ? 6'h00 : pre_cnt + 6'h01;
        end
    end

    // down-counter; a loaded zero stands for 256 counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= `RST_BYTE;
            done  <= 1'b0;
            eoc   <= 1'b0;
        end else begin
            eoc <= step & (count == 8'h01);
            if (load) begin
                count <= reload_val;
                done  <= 1'b0;
            end else if (step) begin
                if (count == 8'h01) begin
                    count <= continuous ? reload_val : 8'h00;
                    done  <= ~continuous;
                end else begin
                    count <= count - 8'h01;
                end
            end
        end
    end
endmodule

// *** src/mcu_interrupts_and_timers.sv ***
`timescale 1ns/100ps
`include "intc_map.svh"
module mcu_interrupts_and_timers
    import intc_pkg::*;
#(
    parameter logic PROTECT_OPTION = 1'b1
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        edge_pin_a,
    input  wire logic        edge_pin_b,
    input  wire logic        edge_pin_c,
    input  wire logic        comparator_a_out,
    input  wire logic        comparator_b_out,
    input  wire logic        signal_proc_line,
    input  wire logic        int_ack,
    input  wire logic        halt_mode,
    output logic             int_request,
    output logic      [15:0] int_vector,
    output logic             halt_wake,
    output logic             upper_protect_en
);
    ////////////////////////////////////////////////////////////////////////////
    logic [4:0]      sync1;
    logic [4:0]      sync2;
    logic [4:0]      prev;
    logic [4:0]      rise;
    logic [4:0]      fall;
    logic            sp_prev;
    logic [2:0]      primed;
    logic [7:0]      req_flags;
    logic [7:0]      mask;
    logic [2:0]      priority_sel;
    logic [7:0]      tmr_mode;
    logic            analog;
    logic [7:0]      t_reload [2];
    logic [7:0]      t_pre [2];
    logic [7:0]      t_count [2];
    logic [1:0]      t_done;
    logic [1:0]      t_eoc;
    logic [1:0]      t_tick;
    logic [1:0]      t_load;
    logic [1:0]      t_run;
    logic [1:0]      div_cnt;
    logic            div4;
    logic [5:0]      set_vec;
    logic [5:0]      en;
    logic [5:0]      ack_clr;
    logic [2:0]      next_winner;
    logic [2:0]      winner;
    logic            any_en;
    grant_state_type state;
    logic            acc;
    logic            wr;
    logic [9:0]      word;
    logic            wr_req;
    logic            wr_mask;
    logic            wr_tmr;
    logic            wr_sp;
    logic [31:0]     next_prdata;
    logic            next_err;
    logic [1:0]      ext_mode;
    logic            trig_mode;

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, every answer comes from a flop
    assign acc     = psel & penable & pready;
    assign wr      = acc & pwrite & (paddr[1:0] == 2'h0);
    assign word    = paddr[11:2];
    assign wr_req  = wr & (word == {2'h0, `IDX_REQ_FLAGS});
    assign wr_mask = wr & (word == {2'h0, `IDX_MASK});
    assign wr_tmr  = wr & (word == {2'h0, `IDX_TMR_MODE});
    assign wr_sp   = wr & (word == {2'h0, `IDX_SP_CONTROL});

    // read mux; counters read live without side effects, prescalers read zero
    always_comb begin
        next_prdata = 32'h0000_0000;
        next_err    = (paddr[1:0] != 2'h0);
        case (word)
            {2'h0, `IDX_REQ_FLAGS}:   next_prdata[7:0] = req_flags;
            {2'h0, `IDX_MASK}:        next_prdata[7:0] = mask;
            {2'h0, `IDX_PRIORITY}:    next_prdata[2:0] = priority_sel;
            {2'h0, `IDX_TMR_MODE}:    next_prdata[7:0] = tmr_mode;
            {2'h0, `IDX_TMR0_RELOAD}:   next_prdata[7:0] = t_count[0];
            {2'h0, `IDX_TMR1_RELOAD}:   next_prdata[7:0] = t_count[1];
            {2'h0, `IDX_TMR0_PRESCALE}: next_prdata = 32'h0000_0000;
            {2'h0, `IDX_TMR1_PRESCALE}: next_prdata = 32'h0000_0000;
            {2'h0, `IDX_SP_CONTROL}:  next_prdata[0] = req_flags[3];
            {2'h0, `IDX_ANALOG_CTRL}: next_prdata[0] = analog;
            default:                  next_err = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & next_err;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // plain configuration registers; load bits of the mode register read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            priority_sel <= `RST_PRIORITY;
            tmr_mode     <= `RST_BYTE;
            analog       <= 1'b0;
            t_reload[0]  <= `RST_BYTE;
            t_reload[1]  <= `RST_BYTE;
            t_pre[0]     <= `RST_BYTE;
            t_pre[1]     <= `RST_BYTE;
        end else if (wr) begin
            case (word)
                {2'h0, `IDX_PRIORITY}:    priority_sel <= pwdata[2:0];
                {2'h0, `IDX_TMR_MODE}:    tmr_mode <= pwdata[7:0] & 8'hFA;
                {2'h0, `IDX_ANALOG_CTRL}: analog <= pwdata[`ANALOG_BIT];
                {2'h0, `IDX_TMR0_RELOAD}:   t_reload[0] <= pwdata[7:0];
                {2'h0, `IDX_TMR1_RELOAD}:   t_reload[1] <= pwdata[7:0];
                {2'h0, `IDX_TMR0_PRESCALE}: t_pre[0] <= pwdata[7:0];
                {2'h0, `IDX_TMR1_PRESCALE}: t_pre[1] <= pwdata[7:0];
                default:                  analog <= analog;
            endcase
        end
    end

    // mask; the acknowledge clears global enable even against a same-cycle write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= `RST_BYTE;
        end else begin
            if (wr_mask) begin
                mask <= pwdata[7:0];
            end
            if (state == ST_WAIT && int_ack) begin
                mask[`MASK_GLOBAL] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers; only sync2 and prev feed the edge logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1   <= 5'h1F;
            sync2   <= 5'h1F;
            prev    <= 5'h1F;
            sp_prev <= 1'b1;
            primed  <= 3'h0;
        end else begin
            primed  <= {primed[1:0], 1'b1};
            sync1   <= {comparator_b_out, comparator_a_out, edge_pin_c, edge_pin_b, edge_pin_a};
            sync2   <= sync1;
            prev    <= sync2;
            sp_prev <= signal_proc_line; // same clock, no synchroniser needed
        end
    end

    // no edges until the pipe holds real samples, so a pin idling low fakes no fall
    assign rise = sync2 & ~prev & {5{primed[2]}};
    assign fall = ~sync2 & prev & {5{primed[2]}};

    // request events; edges are taken per pin ahead of the mode mux, so a mode switch fakes none
    always_comb begin
        logic r0;
        logic f0;
        logic r2;
        logic f2;
        r0 = analog ? rise[4] : rise[1];
        f0 = analog ? fall[4] : fall[1];
        r2 = analog ? rise[3] : rise[0];
        f2 = analog ? fall[3] : fall[0];
        set_vec[0] = (req_flags[6] & r0) | ((~req_flags[6] | req_flags[7]) & f0);
        set_vec[1] = fall[2];
        set_vec[2] = (req_flags[7] & r2) | ((~req_flags[7] | req_flags[6]) & f2);
        set_vec[3] = sp_prev & ~signal_proc_line;
        set_vec[4] = t_eoc[0];
        set_vec[5] = t_eoc[1];
    end

    // pending flags: a new event always beats a clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_flags <= `RST_BYTE;
        end else if (wr_req) begin
            req_flags <= {pwdata[7:6], pwdata[5:0] | set_vec};
        end else begin
            req_flags[5:0] <= (req_flags[5:0] & ~ack_clr & ~{2'h0, wr_sp & pwdata[`SP_CLEAR_BIT], 3'h0})
                              | set_vec;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign en      = req_flags[5:0] & mask[5:0] & {6{mask[`MASK_GLOBAL]}};
    assign any_en  = |en;
    assign ack_clr = (state == ST_WAIT && int_ack) ? 6'(6'h01 << winner) : 6'h00;

    // rotating priority: the selected request ranks first, then upward
    always_comb begin
        int start;
        int idx;
        start       = (priority_sel < 3'h6) ? int'(priority_sel) : 0;
        idx         = 0;
        next_winner = 3'h0;
        for (int k = `NUM_REQ - 1; k >= 0; k--) begin
            idx = (start + k) % `NUM_REQ;
            if (en[idx]) begin
                next_winner = 3'(idx);
            end
        end
    end

    // grant machine: hold the request until the sequencer acknowledges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state       <= ST_IDLE;
            winner      <= 3'h0;
            int_request <= 1'b0;
            int_vector  <= 16'h0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (any_en) begin
                        state       <= ST_WAIT;
                        winner      <= next_winner;
                        int_request <= 1'b1;
                        int_vector  <= {12'h000, next_winner, 1'b0};
                    end
                end
                ST_WAIT: begin
                    if (int_ack) begin
                        state       <= ST_IDLE;
                        int_request <= 1'b0;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // halt keeps this clock running, so any enabled request wakes the cpu
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            halt_wake        <= 1'b0;
            upper_protect_en <= 1'b0;
        end else begin
            halt_wake        <= halt_mode & any_en;
            upper_protect_en <= PROTECT_OPTION & mask[`MASK_PROTECT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // internal timer clock: processor clock divided by four
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= 2'h0;
        end else begin
            div_cnt <= div_cnt + 2'h1;
        end
    end

    assign div4      = (div_cnt == `DIV4_LAST);
    assign ext_mode  = tmr_mode[`TMR_EXT_MODE_LO +: 2];
    assign trig_mode = ext_mode[1];
    assign t_run     = {tmr_mode[`TMR1_RUN], tmr_mode[`TMR0_RUN]};
    assign t_tick[0] = div4;
    // cascade wins over the pin; a gate only qualifies the internal clock
    assign t_tick[1] = tmr_mode[`TMR_CASCADE] ? t_eoc[0] :
                       tmr_mode[`TMR1_INT_SRC] ? (div4 & ((ext_mode != `EXT_GATE) | sync2[0]))
                       : ((ext_mode == `EXT_CLOCK) & fall[0]);
    assign t_load[0] = wr_tmr & pwdata[`TMR0_LOAD];
    // a non-retriggerable trigger is ignored until a single-pass count has run out
    assign t_load[1] = (wr_tmr & pwdata[`TMR1_LOAD])
                       | (trig_mode & fall[0] & ((ext_mode == `EXT_TRIG_RETRIG) | t_done[1]));

    for (genvar g = 0; g < 2; g++) begin : gen_timer
        irq_timer u_timer (
            .pclk       (pclk),
            .presetn    (presetn),
            .tick       (t_tick[g]),
            .run        (t_run[g]),
            .load       (t_load[g]),
            .continuous (t_pre[g][`PRE_CONT_BIT]),
            .reload_val (t_reload[g]),
            .divisor    (t_pre[g][7:2]),
            .count      (t_count[g]),
            .done       (t_done[g]),
            .eoc        (t_eoc[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_VECTOR_RANGE: assert property (@(posedge pclk) disable iff (!presetn)
        int_request |-> (int_vector[15:4] == 12'h000) && !int_vector[0] && (int_vector[3:1] < 3'h6))
        else $error("vector outside the six byte pairs");
    AST_HOLD_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
        int_request && !int_ack |=> int_request && $stable(int_vector))
        else $error("granted request dropped before acknowledge");
    AST_ACK_DISABLES: assert property (@(posedge pclk) disable iff (!presetn)
        int_request && int_ack |=> !mask[`MASK_GLOBAL] && !int_request)
        else $error("acknowledge did not disable interrupts");
    AST_GLOBAL_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !mask[`MASK_GLOBAL] && !int_request |=> !int_request)
        else $error("grant while globally disabled");
    AST_ACK_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
        int_request && int_ack && !wr_req && !set_vec[winner] |=> !req_flags[$past(winner)])
        else $error("granted request still pending");
    AST_POLL_RECORD: assert property (@(posedge pclk) disable iff (!presetn)
        set_vec[1] |=> req_flags[1])
        else $error("masked event not recorded");
    AST_SP_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        wr_sp && pwdata[0] && !set_vec[3] |=> !req_flags[3])
        else $error("processor request not cleared");
    AST_RISE_SEL: assert property (@(posedge pclk) disable iff (!presetn)
        !analog && req_flags[7:6] == 2'h1 && rise[1] && !wr_req |=> req_flags[0])
        else $error("rising edge not taken");
    AST_TMR0_REQUEST: assert property (@(posedge pclk) disable iff (!presetn)
        t_eoc[0] && !wr_req |=> req_flags[4])
        else $error("timer end did not raise request");
    AST_PROTECT: assert property (@(posedge pclk) disable iff (!presetn)
        wr_mask && pwdata[6] && PROTECT_OPTION && !int_ack |=> ##1 upper_protect_en)
        else $error("protection not enabled");
    AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
        halt_mode && any_en |=> halt_wake)
        else $error("halt not woken");
    COV_GRANT: cover property (@(posedge pclk) disable iff (!presetn) $rose(int_request));
    COV_ACK: cover property (@(posedge pclk) disable iff (!presetn) int_request && int_ack);
    COV_TMR1_END: cover property (@(posedge pclk) disable iff (!presetn) t_eoc[1]);
endmodule

// *** test/core_partner.sv ***
`timescale 1ns/100ps
module core_partner (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        int_request,
    input  wire logic [15:0] int_vector,
    input  wire logic        sp_fire,
    input  wire logic [3:0]  ack_delay,
    output logic             signal_proc_line,
    output logic             int_ack,
    output logic      [15:0] taken_vector,
    output logic      [3:0]  taken_count
);
    logic [3:0] wait_cnt;
    logic [1:0] low_cnt;
    ////////////////////////////////////////////////////////////////
    // sequencer: a slow taker, so the request must stand for a while
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= 4'h0;
            int_ack <= 1'b0;
            taken_vector <= 16'h0000;
            taken_count <= 4'h0;
        end else begin
            int_ack <= 1'b0;
            if (int_request && !int_ack) begin
                if (wait_cnt == ack_delay) begin
                    int_ack <= 1'b1;
                    taken_vector <= int_vector;
                    taken_count <= taken_count + 4'h1;
                    wait_cnt <= 4'h0;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
        end
    end
    ////////////////////////////////////////////////////////////////
    // signal processor: line idles high, a fire pulls it low two cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            signal_proc_line <= 1'b1;
            low_cnt <= 2'h0;
        end else if (sp_fire) begin
            signal_proc_line <= 1'b0;
            low_cnt <= 2'h2;
        end else if (low_cnt != 2'h0) begin
            low_cnt <= low_cnt - 2'h1;
            signal_proc_line <= (low_cnt == 2'h1);
        end
    end
endmodule

// *** test/tb_mcu_interrupts_and_timers.sv ***
`timescale 1ns/100ps
`include "intc_map.svh"
module tb_mcu_interrupts_and_timers;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic        pin_a, pin_b, pin_c, halt_mode, sp_fire, sp_line, int_ack, cmp_a, cmp_b;
    logic        int_request, halt_wake, upper_protect_en;
    logic [15:0] int_vector, taken_vector;
    logic [3:0]  taken_count;
    logic [7:0]  hold;
    logic [1:0]  sel;
    int          bad_count, check_count, cycles;

    mcu_interrupts_and_timers dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .edge_pin_a(pin_a), .edge_pin_b(pin_b), .edge_pin_c(pin_c),
        .comparator_a_out(cmp_a), .comparator_b_out(cmp_b), .signal_proc_line(sp_line),
        .int_ack(int_ack), .halt_mode(halt_mode), .int_request(int_request),
        .int_vector(int_vector), .halt_wake(halt_wake), .upper_protect_en(upper_protect_en));

    core_partner partner (
        .pclk(pclk), .presetn(presetn), .int_request(int_request), .int_vector(int_vector),
        .sp_fire(sp_fire), .ack_delay(4'h8), .signal_proc_line(sp_line), .int_ack(int_ack),
        .taken_vector(taken_vector), .taken_count(taken_count));
    ////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the extra edge at the end keeps back-to-back calls race free
    // waits for pready as long as it takes; only the cycle guard ends a hang
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd_data = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd_data, {24'h000000, exp});
    endtask
    task automatic pins(input logic a, input logic b, input logic c);
        pin_a <= a;
        pin_b <= b;
        pin_c <= c;
        repeat (5) @(posedge pclk);
    endtask
    task automatic wait_ack(input logic [3:0] k);
        int n;
        n = 0;
        while (taken_count !== k && n < 100) begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {pin_a, pin_b, pin_c, halt_mode, sp_fire, cmp_a, cmp_b} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`IDX_MASK, 8'h00);
        rd(`IDX_PRIORITY, 8'h00);
        rd(8'h10, 8'h00);
        check({31'h0, last_err}, 32'h1);
        $display("test reset done");
        // every edge select code, rising then falling on all three pins
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            wr(`IDX_REQ_FLAGS, {sel, 6'h00});
            pins(1'b1, 1'b1, 1'b1);
            rd(`IDX_REQ_FLAGS, {sel, 3'h0, sel[1], 1'b0, sel[0]});
            wr(`IDX_REQ_FLAGS, {sel, 6'h00});
            pins(1'b0, 1'b0, 1'b0);
            rd(`IDX_REQ_FLAGS, {sel, 3'h0, sel != 2'h2, 1'b1, sel != 2'h1});
        end
        wr(`IDX_REQ_FLAGS, 8'h00);
        sp_fire <= 1'b1;
        @(posedge pclk);
        sp_fire <= 1'b0;
        repeat (6) @(posedge pclk);
        rd(`IDX_REQ_FLAGS, 8'h08);
        rd(`IDX_SP_CONTROL, 8'h01);
        wr(`IDX_SP_CONTROL, 8'h01);
        rd(`IDX_SP_CONTROL, 8'h00);
        // analog mode: comparators take over both programmable requests
        wr(`IDX_ANALOG_CTRL, 8'h01);
        wr(`IDX_REQ_FLAGS, 8'hC0);
        cmp_a <= 1'b1;
        cmp_b <= 1'b1;
        repeat (5) @(posedge pclk);
        rd(`IDX_REQ_FLAGS, 8'hC5);
        rd(`IDX_ANALOG_CTRL, 8'h01);
        wr(`IDX_ANALOG_CTRL, 8'h00);
        $display("test edges done");
        // masked requests stay pending; global enable then grants by priority
        halt_mode <= 1'b1;
        wr(`IDX_MASK, 8'h05);
        wr(`IDX_REQ_FLAGS, 8'h05);
        wr(`IDX_PRIORITY, 8'h02);
        check({31'h0, int_request}, 32'h0);
        rd(`IDX_REQ_FLAGS, 8'h05);
        wr(`IDX_MASK, 8'h85);
        repeat (2) @(posedge pclk);
        check({31'h0, halt_wake}, 32'h1);
        check({16'h0, int_vector}, 32'h4);
        wait_ack(4'h1);
        check({16'h0, taken_vector}, 32'h4);
        rd(`IDX_MASK, 8'h05);
        rd(`IDX_REQ_FLAGS, 8'h01);
        check({31'h0, halt_wake}, 32'h0);
        wr(`IDX_MASK, 8'h85);
        wait_ack(4'h2);
        check({16'h0, taken_vector}, 32'h0);
        rd(`IDX_REQ_FLAGS, 8'h00);
        halt_mode <= 1'b0;
        wr(`IDX_MASK, 8'h40);
        @(posedge pclk);
        check({31'h0, upper_protect_en}, 32'h1);
        wr(`IDX_MASK, 8'h00);
        $display("test interrupts done");
        // single pass on the first timer, continuous on the second
        wr(`IDX_TMR0_RELOAD, 8'h03);
        wr(`IDX_TMR0_PRESCALE, 8'h04);
        wr(`IDX_TMR_MODE, 8'h03);
        repeat (40) @(posedge pclk);
        rd(`IDX_TMR0_RELOAD, 8'h00);
        rd(`IDX_REQ_FLAGS, 8'h10);
        rd(`IDX_TMR0_PRESCALE, 8'h00);
        wr(`IDX_REQ_FLAGS, 8'h00);
        wr(`IDX_TMR1_RELOAD, 8'h05);
        wr(`IDX_TMR1_PRESCALE, 8'h09);
        wr(`IDX_TMR_MODE, 8'h4C);
        repeat (120) @(posedge pclk);
        rd(`IDX_REQ_FLAGS, 8'h20);
        wr(`IDX_TMR_MODE, 8'h40);
        apb(1'b0, `IDX_TMR1_RELOAD, 8'h00);
        hold = rd_data[7:0];
        repeat (30) @(posedge pclk);
        rd(`IDX_TMR1_RELOAD, hold);
        wr(`IDX_TMR_MODE, 8'h48);
        repeat (16) @(posedge pclk);
        apb(1'b0, `IDX_TMR1_RELOAD, 8'h00);
        check({31'h0, rd_data[7:0] != hold}, 32'h1);
        wr(`IDX_TMR_MODE, 8'h44);
        rd(`IDX_TMR1_RELOAD, 8'h05);
        // cascade: one end of the first timer steps the second exactly once
        wr(`IDX_TMR1_PRESCALE, 8'h04);
        wr(`IDX_TMR_MODE, 8'h8F);
        repeat (40) @(posedge pclk);
        rd(`IDX_TMR1_RELOAD, 8'h04);
        // retriggerable trigger: a falling first pin reloads the second timer
        wr(`IDX_TMR_MODE, 8'h70);
        pins(1'b1, 1'b0, 1'b0);
        pins(1'b0, 1'b0, 1'b0);
        rd(`IDX_TMR1_RELOAD, 8'h05);
        $display("test timers done");
        summarize();
    end
endmodule
